// ===== src/hsd_hook_supervision.sv
// Top of four-channel hook supervision with APB register access
//
// Overview of operation
// - Meter source select 1100 routes ring-trip sense into the threshold comparator.
// - Threshold source bit 1 uses fixed 7 mA; 0 uses programmed threshold word.
// - Programmed threshold word covers zero up to 20 mA.
// - One hook status bit per channel; 0 on-hook, 1 off-hook or ring trip.
// - Offset select 0 applies programmed offset word; 1, the default, applies zero.
// - In serial control mode, scan enable and mode field come from command byte.
// - In active mode compare filtered loop level with threshold; exceed sets hook.
// - Hook bit setting raises interrupt at the same time unless masked.
// - On-hook threshold equals off-hook threshold minus hysteresis.
// - Hysteresis defaults to 2 mA and is programmable by a coefficient word.
// - Every change of any hook bit interrupts when unmasked; none when masked.
`timescale 1ns/10ps
module hsd_hook_supervision (
   input  wire logic                      clk_sys,
   input  wire logic                      rst,
   input  wire logic                      psel,
   input  wire logic                      penable,
   input  wire logic                      pwrite,
   input  wire logic [7:0]                paddr,
   input  wire logic [31:0]               pwdata,
   output logic      [31:0]               prdata,
   output logic                           pready,
   output logic                           pslverr,
   input  wire logic                      sample_valid,
   input  wire hsd_pkg::hsd_sample_t [3:0] sample,
   input  wire hsd_pkg::hsd_ci_t          ci_cmd,
   output logic      [3:0]                hook_status,
   output logic                           hook_irq
);

   ////////////////////////////////////////////////////////////////////////////
   // Registers and state

   logic [hsd_pkg::MODE_W-1:0] channel_mode_reg;
   logic [3:0]                 threshold_source_reg;
   logic [3:0]                 offset_select_reg;
   logic [15:0]                meter_config_reg;
   logic                       interrupt_mask_reg;
   logic [3:0]                 ci_scan;
   logic [11:0]                ci_mode;
   hsd_pkg::hsd_apb_st_t       apb_st;
   hsd_pkg::hsd_apb_st_t       next_apb_st;
   logic [31:0]                next_rdata;
   logic                       next_err;
   logic                       setup;
   logic                       wr;
   logic [15:0]                mem_apb_rd;
   logic [15:0]                mem_scan_rd;
   logic [3:0]                 scan_idx;
   logic [3:0]                 scan_q;
   hsd_pkg::hsd_coef_t [3:0]   coef;
   logic [3:0]                 ch_en;
   logic [3:0]                 next_hook;

   assign setup = psel && !penable;
   assign wr    = psel && penable && pwrite && pready;

   ////////////////////////////////////////////////////////////////////////////
   // APB transfer sequencing

   // Coefficient reads need one extra cycle for the registered memory port
   always_comb
   begin
      next_apb_st = apb_st;
      unique case (apb_st)
         hsd_pkg::AP_IDLE:
            if (setup)
               next_apb_st = (hsd_pkg::hsd_is_coef(paddr) && !pwrite) ? hsd_pkg::AP_WAIT : hsd_pkg::AP_DONE;
         hsd_pkg::AP_WAIT:
            next_apb_st = hsd_pkg::AP_DONE;
         hsd_pkg::AP_DONE:
            next_apb_st = hsd_pkg::AP_IDLE;
         default:
            next_apb_st = hsd_pkg::AP_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
         apb_st <= hsd_pkg::AP_IDLE;
      else
         apb_st <= next_apb_st;
   end

   // Read data and error decode; reserved bits read as zero
   always_comb
   begin
      next_rdata = 32'h0000_0000;
      next_err = 1'b0;
      if (hsd_pkg::hsd_is_coef(paddr))
         next_err = 1'b0;
      else
      begin
         unique case (paddr)
            hsd_pkg::OFF_MODE:   next_rdata = 32'(channel_mode_reg);
            hsd_pkg::OFF_THRSRC: next_rdata = 32'(threshold_source_reg);
            hsd_pkg::OFF_OFFSEL: next_rdata = 32'(offset_select_reg);
            hsd_pkg::OFF_METER:  next_rdata = 32'(meter_config_reg);
            hsd_pkg::OFF_MASK:   next_rdata = 32'(interrupt_mask_reg);
            hsd_pkg::OFF_STATUS: next_rdata = 32'(hook_status);
            default:             next_err = 1'b1;
         endcase
      end
   end

   // Answer signals all leave flip-flops
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         pready <= (next_apb_st == hsd_pkg::AP_DONE);
         if (apb_st == hsd_pkg::AP_IDLE && setup)
         begin
            prdata <= next_rdata;
            pslverr <= next_err;
         end
         else if (apb_st == hsd_pkg::AP_WAIT)
            prdata <= {16'h0000, mem_apb_rd};
         else if (apb_st == hsd_pkg::AP_DONE)
            pslverr <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control registers

   // Writes land only at the edge that completes the access phase
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         channel_mode_reg <= hsd_pkg::RST_MODE;
         threshold_source_reg <= hsd_pkg::RST_THRSRC;
         offset_select_reg <= hsd_pkg::RST_OFFSEL;
         meter_config_reg <= hsd_pkg::RST_METER;
         interrupt_mask_reg <= hsd_pkg::RST_MASK;
      end
      else if (wr)
      begin
         unique case (paddr)
            hsd_pkg::OFF_MODE:   channel_mode_reg <= pwdata[hsd_pkg::MODE_W-1:0];
            hsd_pkg::OFF_THRSRC: threshold_source_reg <= pwdata[3:0];
            hsd_pkg::OFF_OFFSEL: offset_select_reg <= pwdata[3:0];
            hsd_pkg::OFF_METER:  meter_config_reg <= pwdata[15:0];
            hsd_pkg::OFF_MASK:   interrupt_mask_reg <= pwdata[0];
            default:             ;
         endcase
      end
   end

   // Downstream command byte shadow for serial control mode
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         ci_scan <= 4'h0;
         ci_mode <= 12'h000;
      end
      else if (ci_cmd.valid)
      begin
         ci_scan[ci_cmd.chan] <= ci_cmd.scan_en;
         ci_mode[ci_cmd.chan*3 +: 3] <= ci_cmd.mode;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Coefficient store and round-robin working copy

   hsd_coef_mem u_mem (
      .clk_sys   (clk_sys),
      .rst       (rst),
      .wr_en     (wr && hsd_pkg::hsd_is_coef(paddr)),
      .wr_idx    (paddr[5:2]),
      .wr_data   (pwdata[15:0]),
      .rd_a_idx  (paddr[5:2]),
      .rd_a_data (mem_apb_rd),
      .rd_b_idx  (scan_idx),
      .rd_b_data (mem_scan_rd)
   );

   // Working copy trails a coefficient write by at most 17 cycles
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         scan_idx <= 4'h0;
         scan_q <= 4'h0;
      end
      else
      begin
         scan_idx <= scan_idx + 4'h1;
         scan_q <= scan_idx;
      end
   end

   // One shared threshold word per channel serves off-hook and ring trip
   always_ff @(posedge clk_sys)
   begin
      if (rst)
         coef <= '0;
      else
      begin
         unique case (scan_q[1:0])
            hsd_pkg::CW_THR:  coef[scan_q[3:2]].thr <= mem_scan_rd;
            hsd_pkg::CW_HYST: coef[scan_q[3:2]].hyst <= mem_scan_rd;
            hsd_pkg::CW_OFF:  coef[scan_q[3:2]].off <= mem_scan_rd;
            default:          ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Channels

   generate
      for (genvar i = 0; i < hsd_pkg::NCH; i++)
      begin : g_ch
         logic       eff_scan;
         logic [2:0] eff_mode;

         // Sleep comparator lives elsewhere, so standby stops this path
         always_comb
         begin
            eff_scan = channel_mode_reg[hsd_pkg::MODE_SER] ? ci_scan[i]
                                                           : channel_mode_reg[hsd_pkg::MODE_SCAN+i];
            eff_mode = channel_mode_reg[hsd_pkg::MODE_SER] ? ci_mode[i*3 +: 3]
                                                           : channel_mode_reg[hsd_pkg::MODE_LIM+i*3 +: 3];
            ch_en[i] = channel_mode_reg[hsd_pkg::MODE_ACT+i] && !channel_mode_reg[hsd_pkg::MODE_STBY+i]
                       && hsd_pkg::hsd_mode_ok(eff_scan, eff_mode);
         end

         hsd_chan u_chan (
            .clk_sys      (clk_sys),
            .rst          (rst),
            .enable       (ch_en[i]),
            .sample_valid (sample_valid),
            .sample       (sample[i]),
            .meter_sel    (meter_config_reg[i*4 +: 4]),
            .thr_from_rom (threshold_source_reg[i]),
            .off_from_rom (offset_select_reg[i]),
            .coef         (coef[i]),
            .next_hook    (next_hook[i]),
            .hook         (hook_status[i])
         );

         // Standby must freeze the bit, since the sleep comparator is not part of this path
         chk_standby_hold: assert property (@(posedge clk_sys) disable iff (rst)
            channel_mode_reg[hsd_pkg::MODE_STBY+i] |=> $stable(hook_status[i]))
            else $error("hook changed while channel in standby");
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt pulse

   // Raised on the same edge the status changes, so software sees both together
   always_ff @(posedge clk_sys)
   begin
      if (rst)
         hook_irq <= 1'b0;
      else
         hook_irq <= (next_hook != hook_status) && !interrupt_mask_reg;
   end

   sequence s_status_moves;
      hook_status != $past(hook_status);
   endsequence

   chk_irq_on_change: assert property (@(posedge clk_sys) disable iff (rst)
      s_status_moves and !$past(interrupt_mask_reg) |-> hook_irq)
      else $error("hook change without interrupt");
   chk_irq_has_cause: assert property (@(posedge clk_sys) disable iff (rst)
      hook_irq |-> hook_status != $past(hook_status) && !$past(interrupt_mask_reg))
      else $error("interrupt without unmasked hook change");
   chk_apb_answer: assert property (@(posedge clk_sys) disable iff (rst)
      psel && !penable |=> ##[0:1] pready)
      else $error("apb access not answered in two cycles");
   chk_serial_source: assert property (@(posedge clk_sys) disable iff (rst)
      channel_mode_reg[24] && channel_mode_reg[0] && !channel_mode_reg[4] && !ci_scan[0] |-> !ch_en[0])
      else $error("register scan enable used in serial mode");
   chk_ready_pulse: assert property (@(posedge clk_sys) disable iff (rst)
      pready |=> !pready)
      else $error("pready held for more than one cycle");
   chk_err_with_ready: assert property (@(posedge clk_sys) disable iff (rst)
      pslverr |-> pready)
      else $error("pslverr raised outside the answer cycle");
   chk_mask_silent: assert property (@(posedge clk_sys) disable iff (rst)
      interrupt_mask_reg |=> !hook_irq)
      else $error("interrupt raised while masked");

endmodule // hsd_hook_supervision

// ===== src/hsd_pkg.sv
// Shared constants, carrier types and decode helpers for hook supervision
package hsd_pkg;

   localparam int NCH = 4;
   localparam int SW  = 16;

   // Register byte offsets
   localparam logic [7:0] OFF_MODE   = 8'h00;
   localparam logic [7:0] OFF_THRSRC = 8'h04;
   localparam logic [7:0] OFF_OFFSEL = 8'h08;
   localparam logic [7:0] OFF_METER  = 8'h0c;
   localparam logic [7:0] OFF_MASK   = 8'h10;
   localparam logic [7:0] OFF_STATUS = 8'h14;
   localparam logic [7:0] OFF_COEF   = 8'h40;
   localparam logic [1:0] COEF_TOP   = 2'h1;

   // Field positions in the channel mode register
   localparam int MODE_ACT  = 0;
   localparam int MODE_STBY = 4;
   localparam int MODE_SCAN = 8;
   localparam int MODE_LIM  = 12;
   localparam int MODE_SER  = 24;
   localparam int MODE_W    = 25;

   // Reset values
   localparam logic [MODE_W-1:0] RST_MODE   = 25'h0;
   localparam logic [NCH-1:0]    RST_THRSRC = 4'hf;
   localparam logic [NCH-1:0]    RST_OFFSEL = 4'hf;
   localparam logic [15:0]       RST_METER  = 16'h0;
   localparam logic              RST_MASK   = 1'b0;

   // Encodings
   localparam logic [2:0] LIM_ACTIVE  = 3'h0;
   localparam logic [2:0] LIM_EXTRING = 3'h1;
   localparam logic [2:0] LIM_SLEEP   = 3'h6;
   localparam logic [3:0] METER_RING_TRIP_SENSE_INPUT  = 4'hc;
   localparam logic [1:0] CW_THR      = 2'h0;
   localparam logic [1:0] CW_HYST     = 2'h1;
   localparam logic [1:0] CW_OFF      = 2'h2;

   // Loop current scale: one code step is 10 uA
   localparam int LSB_UA      = 10;
   localparam int ROM_THR_UA  = 7000;
   localparam int ROM_HYST_UA = 2000;
   localparam int MAX_THR_UA  = 20000;
   localparam logic [SW-1:0] ROM_THR  = SW'(ROM_THR_UA / LSB_UA);
   localparam logic [SW-1:0] ROM_HYST = SW'(ROM_HYST_UA / LSB_UA);
   localparam logic [SW-1:0] MAX_THR  = SW'(MAX_THR_UA / LSB_UA);

   typedef struct packed {
      logic [SW-1:0] rt;
      logic [SW-1:0] dc;
   } hsd_sample_t;

   typedef struct packed {
      logic [SW-1:0] thr;
      logic [SW-1:0] hyst;
      logic [SW-1:0] off;
   } hsd_coef_t;

   typedef struct packed {
      logic       valid;
      logic [1:0] chan;
      logic       scan_en;
      logic [2:0] mode;
   } hsd_ci_t;

   typedef enum logic [1:0] {
      AP_IDLE = 2'b00,
      AP_WAIT = 2'b01,
      AP_DONE = 2'b11
   } hsd_apb_st_t;

   // Line interface set up for supervision: active or external ringing
   function automatic logic hsd_mode_ok(input logic scan, input logic [2:0] mode);
      return scan && (mode == LIM_ACTIVE || mode == LIM_EXTRING);
   endfunction

   function automatic logic hsd_is_coef(input logic [7:0] addr);
      return addr[7:6] == COEF_TOP;
   endfunction

endpackage

// ===== src/hsd_coef_mem.sv
// Coefficient word store with one write port and two registered read ports
`timescale 1ns/10ps
module hsd_coef_mem (
   input  wire logic        clk_sys,
   input  wire logic        rst,
   input  wire logic        wr_en,
   input  wire logic [3:0]  wr_idx,
   input  wire logic [15:0] wr_data,
   input  wire logic [3:0]  rd_a_idx,
   output logic      [15:0] rd_a_data,
   input  wire logic [3:0]  rd_b_idx,
   output logic      [15:0] rd_b_data
);

   logic [15:0] mem [16];

   // Storage carries no reset; software loads words before relying on them
   always_ff @(posedge clk_sys)
   begin
      if (wr_en)
      begin
         mem[wr_idx] <= wr_data;
      end
   end

   // Both read ports registered
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         rd_a_data <= 16'h0000;
         rd_b_data <= 16'h0000;
      end
      else
      begin
         rd_a_data <= mem[rd_a_idx];
         rd_b_data <= mem[rd_b_idx];
      end
   end

endmodule // hsd_coef_mem

// ===== src/hsd_chan.sv
// One channel of loop supervision: source select, offset, threshold, hysteresis
`timescale 1ns/10ps
module hsd_chan (
   input  wire logic                clk_sys,
   input  wire logic                rst,
   input  wire logic                enable,
   input  wire logic                sample_valid,
   input  wire hsd_pkg::hsd_sample_t sample,
   input  wire logic [3:0]          meter_sel,
   input  wire logic                thr_from_rom,
   input  wire logic                off_from_rom,
   input  wire hsd_pkg::hsd_coef_t  coef,
   output logic                     next_hook,
   output logic                     hook
);

   logic [15:0] src;
   logic [15:0] offs;
   logic [17:0] sum;
   logic [15:0] level;
   logic [15:0] thr;
   logic [15:0] hys;
   logic [15:0] on_thr;

   // Input routing, offset and threshold selection
   always_comb
   begin
      src = (meter_sel == hsd_pkg::METER_RING_TRIP_SENSE_INPUT) ? sample.rt : sample.dc;
      offs = off_from_rom ? 16'h0000 : coef.off;
      sum = {2'b00, src} + {{2{offs[15]}}, offs};
      // Saturate so a large negative offset cannot wrap into off-hook
      if (sum[17])
         level = 16'h0000;
      else if (sum[16])
         level = 16'hffff;
      else
         level = sum[15:0];
      if (thr_from_rom)
         thr = hsd_pkg::ROM_THR;
      else if (coef.thr > hsd_pkg::MAX_THR)
         thr = hsd_pkg::MAX_THR;
      else
         thr = coef.thr;
      hys = thr_from_rom ? hsd_pkg::ROM_HYST : coef.hyst;
      on_thr = (hys > thr) ? 16'h0000 : 16'(thr - hys);
   end

   // Hook decision with hysteresis; held while supervision is off
   always_comb
   begin
      next_hook = hook;
      if (enable && sample_valid)
      begin
         if (!hook && level > thr)
            next_hook = 1'b1;
         else if (hook && level < on_thr)
            next_hook = 1'b0;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
         hook <= 1'b0;
      else
         hook <= next_hook;
   end

   sequence s_sample;
      enable && sample_valid;
   endsequence

   chk_offhook_set: assert property (@(posedge clk_sys) disable iff (rst)
      s_sample and !hook && level > thr |=> hook)
      else $error("off-hook level did not set hook");
   chk_onhook_clear: assert property (@(posedge clk_sys) disable iff (rst)
      s_sample and hook && level < on_thr |=> !hook)
      else $error("on-hook level did not clear hook");
   chk_hyst_band_hold: assert property (@(posedge clk_sys) disable iff (rst)
      hook && level >= on_thr |=> hook)
      else $error("hook dropped inside hysteresis band");
   chk_rom_values: assert property (@(posedge clk_sys) disable iff (rst)
      s_sample and thr_from_rom && !hook && level > hsd_pkg::ROM_THR |=> hook)
      else $error("fixed 7 mA threshold not applied");
   chk_ring_trip_sense_input_route: assert property (@(posedge clk_sys) disable iff (rst)
      s_sample and meter_sel == hsd_pkg::METER_RING_TRIP_SENSE_INPUT && off_from_rom && !hook && sample.rt > thr |=> hook)
      else $error("ring trip sense not routed to comparator");
   chk_idle_hold: assert property (@(posedge clk_sys) disable iff (rst)
      !enable |=> $stable(hook))
      else $error("hook changed while supervision disabled");

endmodule // hsd_chan

// ===== verif/hsd_line_model.sv
// Line interface and host command model that feeds loop samples and command bytes
`timescale 1ns/10ps
module hsd_line_model (
   input  wire logic                  clk_sys,
   output logic                       sample_valid,
   output hsd_pkg::hsd_sample_t [3:0] sample,
   output hsd_pkg::hsd_ci_t           ci_cmd
);
   ////////////////////////////////////////////////////////////////////////////
   // Quiet start: every loop on-hook, no strobe and no command
   initial
   begin
      sample_valid = 1'b0;
      sample       = '0;
      ci_cmd       = '0;
   end

   // Loop levels persist between strobes, just as a real line current does
   task automatic send(input int ch, input logic [15:0] dc, input logic [15:0] rt);
      @(posedge clk_sys);
      sample[ch]   <= {rt, dc};
      sample_valid <= 1'b1;
      @(posedge clk_sys);
      sample_valid <= 1'b0;
   endtask

   // Command byte is a one-cycle pulse; fields are scrambled once released
   task automatic cmd(input logic [1:0] ch, input logic scan, input logic [2:0] mode);
      @(posedge clk_sys);
      ci_cmd <= {1'b1, ch, scan, mode};
      @(posedge clk_sys);
      ci_cmd <= {1'b0, ~ch, ~scan, ~mode};
   endtask
endmodule // hsd_line_model

// ===== verif/testbench.sv
// Self-checking bench for four-channel hook supervision over APB
`timescale 1ns/10ps
module testbench;
   logic                       clk_sys;
   logic                       rst;
   logic                       psel;
   logic                       penable;
   logic                       pwrite;
   logic [7:0]                 paddr;
   logic [31:0]                pwdata;
   logic [31:0]                prdata;
   logic                       pready;
   logic                       pslverr;
   logic                       sample_valid;
   hsd_pkg::hsd_sample_t [3:0] sample;
   hsd_pkg::hsd_ci_t           ci_cmd;
   logic [3:0]                 hook_status;
   logic                       hook_irq;
   int                         mismatches;
   int                         num_checks;
   logic [31:0]                rdv;
   logic                       err;

   ////////////////////////////////////////////////////////////////////////////
   hsd_hook_supervision uut (
      .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .sample_valid(sample_valid), .sample(sample), .ci_cmd(ci_cmd),
      .hook_status(hook_status), .hook_irq(hook_irq)
   );
   hsd_line_model line (
      .clk_sys(clk_sys), .sample_valid(sample_valid), .sample(sample), .ci_cmd(ci_cmd)
   );

   // 10 MHz system clock
   initial
   begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic conclude();
      $display("Checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // One APB transfer; waits for pready under a bound, never assumes a latency
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_sys);
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk_sys);
         n++;
      end
      while (pready !== 1'b1 && n < 10);
      rdv = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1)
      begin
         mismatches++;
         conclude();
      end
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check("read data", rdv, exp);
   endtask

   // Coefficient words reach the comparator within 17 cycles of a write
   task automatic settle();
      repeat (20) @(posedge clk_sys);
   endtask

   // New level on one channel; hook bits and the pulse land at the next edge
   task automatic sense(input int ch, input logic [15:0] dc, input logic [15:0] rt,
                        input logic [3:0] eh, input logic ei);
      line.send(ch, dc, rt);
      #1;
      check("hook_status", {28'h0, hook_status}, {28'h0, eh});
      check("hook_irq", {31'h0, hook_irq}, {31'h0, ei});
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Reset values, read-only status and refusal of unmapped offsets
   task automatic t_reset();
      rd(8'h00, 32'h0);
      rd(8'h04, 32'hf);
      rd(8'h08, 32'hf);
      rd(8'h0c, 32'h0);
      rd(8'h10, 32'h0);
      apb(1'b1, 8'h14, 32'hf);
      check("mapped err", {31'h0, err}, 32'h0);
      rd(8'h14, 32'h0);
      apb(1'b0, 8'h18, 32'h0);
      check("unmapped err", {31'h0, err}, 32'h1);
      check("unmapped data", rdv, 32'h0);
   endtask

   // Fixed 7 mA threshold with 2 mA hysteresis on channel 1
   task automatic t_rom();
      apb(1'b1, 8'h00, 32'h0000_0101);
      sense(0, 16'd700, 16'hffff, 4'h0, 1'b0);
      sense(0, 16'd701, 16'h0, 4'h1, 1'b1);
      rd(8'h14, 32'h1);
      sense(0, 16'd500, 16'h0, 4'h1, 1'b0);
      sense(0, 16'd499, 16'h0, 4'h0, 1'b1);
   endtask

   // Masked changes raise no pulse
   task automatic t_mask();
      apb(1'b1, 8'h10, 32'h1);
      rd(8'h10, 32'h1);
      sense(0, 16'd701, 16'h0, 4'h1, 1'b0);
      sense(0, 16'd0, 16'h0, 4'h0, 1'b0);
      apb(1'b1, 8'h10, 32'h0);
   endtask

   // Programmed threshold on channel 2 in external ringing, beside channel 1
   task automatic t_coef();
      apb(1'b1, 8'h00, 32'h0000_8303);
      apb(1'b1, 8'h04, 32'hd);
      apb(1'b1, 8'h50, 32'h3e8);
      apb(1'b1, 8'h54, 32'h64);
      rd(8'h50, 32'h3e8);
      settle();
      sense(0, 16'd800, 16'h0, 4'h1, 1'b1);
      sense(1, 16'd1000, 16'h0, 4'h1, 1'b0);
      sense(1, 16'd1001, 16'h0, 4'h3, 1'b1);
      sense(1, 16'd900, 16'h0, 4'h3, 1'b0);
      sense(1, 16'd899, 16'h0, 4'h1, 1'b1);
      apb(1'b1, 8'h50, 32'hffff);
      settle();
      sense(1, 16'd2000, 16'h0, 4'h1, 1'b0);
      sense(1, 16'd2001, 16'h0, 4'h3, 1'b1);
      sense(1, 16'd0, 16'h0, 4'h1, 1'b1);
      sense(0, 16'd0, 16'h0, 4'h0, 1'b1);
   endtask

   // Ring-trip sense reaches the comparator only when selected on channel 3
   task automatic t_meter();
      apb(1'b1, 8'h00, 32'h0000_8707);
      apb(1'b1, 8'h0c, 32'h0000_0c00);
      sense(2, 16'd0, 16'd701, 4'h4, 1'b1);
      apb(1'b1, 8'h0c, 32'h0);
      sense(2, 16'd0, 16'd701, 4'h0, 1'b1);
   endtask

   // Programmed offset against the zero default on channel 4
   task automatic t_offset();
      apb(1'b1, 8'h00, 32'h0000_8f0f);
      apb(1'b1, 8'h08, 32'h7);
      apb(1'b1, 8'h78, 32'hff9c);
      settle();
      sense(3, 16'd750, 16'h0, 4'h0, 1'b0);
      sense(3, 16'd801, 16'h0, 4'h8, 1'b1);
      sense(3, 16'd0, 16'h0, 4'h0, 1'b1);
      apb(1'b1, 8'h08, 32'hf);
      settle();
      sense(3, 16'd750, 16'h0, 4'h8, 1'b1);
      sense(3, 16'd0, 16'h0, 4'h0, 1'b1);
   endtask

   // Serial control: scan enable and line mode come from the command byte
   task automatic t_serial();
      apb(1'b1, 8'h00, 32'h0100_000f);
      line.cmd(2'h0, 1'b1, 3'h0);
      sense(0, 16'd701, 16'h0, 4'h1, 1'b1);
      line.cmd(2'h0, 1'b1, 3'h6);
      sense(0, 16'd0, 16'h0, 4'h1, 1'b0);
      apb(1'b1, 8'h00, 32'h0000_0111);
      sense(0, 16'd0, 16'h0, 4'h1, 1'b0);
      apb(1'b1, 8'h00, 32'h0000_0101);
      sense(0, 16'd0, 16'h0, 4'h0, 1'b1);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      mismatches = 0;
      num_checks = 0;
      rst        = 1'b1;
      psel       = 1'b0;
      penable    = 1'b0;
      pwrite     = 1'b0;
      paddr      = 8'h00;
      pwdata     = 32'h0;
      repeat (4) @(posedge clk_sys);
      rst <= 1'b0;
      t_reset();
      t_rom();
      t_mask();
      t_coef();
      t_meter();
      t_offset();
      t_serial();
      conclude();
   end
endmodule // testbench
